// ### design/pfr_top.sv
// AHB-Lite pin-function select, input routing, port and wake-up block
// Contract
// RULE1 - Port B pin 0 code 01 selects analog channel 0, others keep general I/O.
// RULE2 - Upper four bits of port B high select and second routing read zero.
// RULE3 - Port B pin 5: 01 serial data out, 10 serial clock, else I/O.
// RULE4 - Port B pin 4: 01 serial data in, else I/O with timer clock.
// RULE5 - Serial clock source: 00 A2, 01 A7, 10 B5, 11 A4.
// RULE6 - Serial data in source: 00 A0, 01 A1, 10 A5, 11 B4.
// RULE7 - Timer capture source: 00/01 from A4, 10/11 from B5.
// RULE8 - Timer clock source: 00/01 from A3, 10/11 from B4.
// RULE9 - External interrupt source: 00/01 A1, 10 A5, 11 A7.
// RULE10 - Chip-select source: 00/11 A0, 01 A3, 10 A6.
// RULE11 - Reset sets all port data and direction registers to ones.
// RULE12 - Output pins drive their data register value.
// RULE13 - Single-bit set/clear reads whole port, changes one bit, writes back.
// RULE14 - Falling edge on wake-enabled port A pin wakes device from sleep.
// RULE15 - Software configures timer pin selections before using timer pins.
// RULE16 - Software sets both output select and input routing for shared inputs.
// RULE17 - Select registers byte-wide, read/write, zero at reset, routing combinational.
module pfr_top (
    input wire logic hclk, // System clock
    input wire logic hresetn, // Async reset, active low
    input wire logic hsel, // Slave select
    input wire logic [31:0] haddr, // Byte address
    input wire logic [1:0] htrans, // Transfer type
    input wire logic hwrite, // Write when high
    input wire logic [2:0] hsize, // Transfer size
    input wire logic [31:0] hwdata, // Write data
    input wire logic hready, // Bus ready
    output logic hreadyout, // Slave ready
    output logic hresp, // Always OKAY
    output logic [31:0] hrdata, // Read data
    input wire logic [7:0] pa_in, // Port A pin levels
    output logic [7:0] pa_out, // Port A drive value
    output logic [7:0] pa_oe, // Port A drive enable
    input wire logic [5:0] pb_in, // Port B pin levels
    output logic [5:0] pb_out, // Port B drive value
    output logic [5:0] pb_oe, // Port B drive enable
    input wire logic sleep_mode, // Device in sleep or idle
    output logic wake_req, // Wake request
    input wire logic serial_data_out_line, // Serial transmit from peripheral
    input wire logic serial_clock_drive, // Serial clock from peripheral
    output logic serial_clock_in, // Routed serial clock
    output logic serial_data_in_line, // Routed serial data in
    output logic serial_chip_select, // Routed chip select
    output logic ext_irq_in, // Routed external interrupt
    output logic timer_capture_input, // Routed timer capture
    output logic timer_external_clock_input, // Routed timer clock
    output logic analog_channel_0_en // Pin B0 given to analog
);
    import pfr_pkg::*;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Pick one of four sources by a two-bit code
    function automatic logic pfr_pick(input logic [1:0] code, input logic [3:0] src);
        return src[code];
    endfunction : pfr_pick

    // Write strobe for one register in the data phase
    function automatic logic pfr_wsel(input logic pend, input logic [7:0] a,
                                      input logic [7:0] off);
        return pend && (a == off);
    endfunction : pfr_wsel

    logic wr_pend_q;
    logic [7:0] wr_addr_q;
    logic [31:0] hrdata_q;
    logic hreadyout_q;
    logic hresp_q;
    logic [7:0] pb_lo_sel_q;
    logic [7:0] pb_hi_sel_q;
    logic [7:0] route0_q;
    logic [7:0] route1_q;
    logic [7:0] wake_en_q;
    logic [7:0] pa_out_q;
    logic [7:0] pa_oe_q;
    logic [5:0] pb_out_q;
    logic [5:0] pb_oe_q;
    logic wake_w;
    logic [7:0] pa_data;
    logic [7:0] pa_dir;
    logic [5:0] pb_data;
    logic [5:0] pb_dir;

    // ------------------------------------------------------------
    // Bus address phase and decode
    // ------------------------------------------------------------
    logic ap_valid;
    logic in_range;
    logic [7:0] ap_addr;
    assign ap_valid = hsel && htrans[1] && hready;
    assign in_range = (haddr[31:PFR_DEC_W] == '0);
    assign ap_addr = in_range ? haddr[PFR_DEC_W-1:0] : PFR_OFF_PIN_STAT + 8'h04;

    // Data-phase write strobes
    logic wr_pb_lo;
    logic wr_pb_hi;
    logic wr_route0;
    logic wr_route1;
    logic wr_pa_data;
    logic wr_pa_dir;
    logic wr_pb_data;
    logic wr_pb_dir;
    logic wr_wake;
    logic wr_bop;
    assign wr_pb_lo = pfr_wsel(wr_pend_q, wr_addr_q, PFR_OFF_PB_LO_SEL);
    assign wr_pb_hi = pfr_wsel(wr_pend_q, wr_addr_q, PFR_OFF_PB_HI_SEL);
    assign wr_route0 = pfr_wsel(wr_pend_q, wr_addr_q, PFR_OFF_ROUTE0);
    assign wr_route1 = pfr_wsel(wr_pend_q, wr_addr_q, PFR_OFF_ROUTE1);
    assign wr_pa_data = pfr_wsel(wr_pend_q, wr_addr_q, PFR_OFF_PA_DATA);
    assign wr_pa_dir = pfr_wsel(wr_pend_q, wr_addr_q, PFR_OFF_PA_DIR);
    assign wr_pb_data = pfr_wsel(wr_pend_q, wr_addr_q, PFR_OFF_PB_DATA);
    assign wr_pb_dir = pfr_wsel(wr_pend_q, wr_addr_q, PFR_OFF_PB_DIR);
    assign wr_wake = pfr_wsel(wr_pend_q, wr_addr_q, PFR_OFF_WAKE_EN);
    assign wr_bop = pfr_wsel(wr_pend_q, wr_addr_q, PFR_OFF_BIT_OP);

    // Bit operation fields
    pfr_tgt_type bop_tgt;
    logic bop_set;
    logic [2:0] bop_idx;
    logic bop_pa;
    logic bop_pb;
    assign bop_tgt = pfr_tgt_type'(hwdata[PFR_BOP_TGT_LSB +: 2]);
    assign bop_set = hwdata[PFR_BOP_SET_BIT];
    assign bop_idx = hwdata[PFR_BOP_IDX_LSB +: 3];
    assign bop_pa = wr_bop && (bop_tgt == PFR_TGT_PA_DATA || bop_tgt == PFR_TGT_PA_DIR);
    assign bop_pb = wr_bop && (bop_tgt == PFR_TGT_PB_DATA || bop_tgt == PFR_TGT_PB_DIR);

    // Read mux, upper nibbles of the half registers stay zero
    logic [31:0] rd_word;
    assign rd_word =
        (ap_addr == PFR_OFF_PB_LO_SEL) ? {24'h000000, pb_lo_sel_q} :
        (ap_addr == PFR_OFF_PB_HI_SEL) ? {24'h000000, pb_hi_sel_q & PFR_LO_NIBBLE} : // RULE2
        (ap_addr == PFR_OFF_ROUTE0) ? {24'h000000, route0_q} :
        (ap_addr == PFR_OFF_ROUTE1) ? {24'h000000, route1_q & PFR_LO_NIBBLE} : // RULE2
        (ap_addr == PFR_OFF_PA_DATA) ? {24'h000000, pa_data} :
        (ap_addr == PFR_OFF_PA_DIR) ? {24'h000000, pa_dir} :
        (ap_addr == PFR_OFF_PB_DATA) ? {26'h0000000, pb_data} :
        (ap_addr == PFR_OFF_PB_DIR) ? {26'h0000000, pb_dir} :
        (ap_addr == PFR_OFF_WAKE_EN) ? {24'h000000, wake_en_q} :
        (ap_addr == PFR_OFF_PIN_STAT) ?
            {15'h0000, wake_w, 2'b00, pb_in, pa_in} : 32'h00000000;

    // Address phase capture and read data
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
            hrdata_q <= 32'h00000000;
            hreadyout_q <= 1'b1;
            hresp_q <= 1'b0;
        end else begin
            wr_pend_q <= ap_valid && hwrite;
            wr_addr_q <= ap_addr;
            if (ap_valid && !hwrite) begin
                hrdata_q <= rd_word;
            end
        end
    end

    // ------------------------------------------------------------
    // Selection, routing and wake-enable registers
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pb_lo_sel_q <= PFR_SEL_RST; // RULE17
            pb_hi_sel_q <= PFR_SEL_RST; // RULE17
            route0_q <= PFR_SEL_RST; // RULE17
            route1_q <= PFR_SEL_RST; // RULE17
            wake_en_q <= PFR_SEL_RST;
        end else begin
            if (wr_pb_lo) pb_lo_sel_q <= hwdata[7:0];
            if (wr_pb_hi) pb_hi_sel_q <= hwdata[7:0] & PFR_LO_NIBBLE; // RULE2
            if (wr_route0) route0_q <= hwdata[7:0];
            if (wr_route1) route1_q <= hwdata[7:0] & PFR_LO_NIBBLE; // RULE2
            if (wr_wake) wake_en_q <= hwdata[7:0]; // RULE14
        end
    end

    // Field views
    logic [1:0] portb_pin0_select;
    logic [1:0] portb_pin4_select;
    logic [1:0] portb_pin5_select;
    logic [1:0] serial_clock_route;
    logic [1:0] serial_data_in_route;
    logic [1:0] capture_in_route;
    logic [1:0] timer_clock_in_route;
    logic [1:0] ext_irq_route;
    logic [1:0] chip_select_route;
    assign portb_pin0_select = pb_lo_sel_q[PFR_PIN0_SEL_LSB +: 2];
    assign portb_pin4_select = pb_hi_sel_q[PFR_PIN4_SEL_LSB +: 2];
    assign portb_pin5_select = pb_hi_sel_q[PFR_PIN5_SEL_LSB +: 2];
    assign serial_clock_route = route0_q[PFR_SCK_LSB +: 2];
    assign serial_data_in_route = route0_q[PFR_SDI_LSB +: 2];
    assign capture_in_route = route0_q[PFR_CAP_LSB +: 2];
    assign timer_clock_in_route = route0_q[PFR_TCK_LSB +: 2];
    assign ext_irq_route = route1_q[PFR_IRQ_LSB +: 2];
    assign chip_select_route = route1_q[PFR_CS_LSB +: 2];

    // ------------------------------------------------------------
    // Input routing, combinational from fields and pins
    // ------------------------------------------------------------
    assign serial_clock_in = pfr_pick(serial_clock_route,
        {pa_in[4], pb_in[5], pa_in[7], pa_in[2]}); // RULE5
    assign serial_data_in_line = pfr_pick(serial_data_in_route,
        {pb_in[4], pa_in[5], pa_in[1], pa_in[0]}); // RULE6
    assign timer_capture_input = pfr_pick(capture_in_route,
        {pb_in[5], pb_in[5], pa_in[4], pa_in[4]}); // RULE7
    assign timer_external_clock_input = pfr_pick(timer_clock_in_route,
        {pb_in[4], pb_in[4], pa_in[3], pa_in[3]}); // RULE8
    assign ext_irq_in = pfr_pick(ext_irq_route,
        {pa_in[7], pa_in[5], pa_in[1], pa_in[1]}); // RULE9
    assign serial_chip_select = pfr_pick(chip_select_route,
        {pa_in[0], pa_in[6], pa_in[3], pa_in[0]}); // RULE10
    assign analog_channel_0_en = (portb_pin0_select == PFR_PIN0_ANALOG); // RULE1

    // ------------------------------------------------------------
    // Ports and wake-up
    // ------------------------------------------------------------
    pfr_port #(.W(PFR_PA_W)) u_port_a (
        .hclk(hclk),
        .hresetn(hresetn),
        .data_wr(wr_pa_data),
        .dir_wr(wr_pa_dir),
        .wr_byte(hwdata[7:0]),
        .bit_op(bop_pa),
        .bit_on_dir(bop_tgt == PFR_TGT_PA_DIR),
        .bit_val(bop_set),
        .bit_idx(bop_idx),
        .data_o(pa_data),
        .dir_o(pa_dir)
    );

    pfr_port #(.W(PFR_PB_W)) u_port_b (
        .hclk(hclk),
        .hresetn(hresetn),
        .data_wr(wr_pb_data),
        .dir_wr(wr_pb_dir),
        .wr_byte(hwdata[7:0]),
        .bit_op(bop_pb),
        .bit_on_dir(bop_tgt == PFR_TGT_PB_DIR),
        .bit_val(bop_set),
        .bit_idx(bop_idx),
        .data_o(pb_data),
        .dir_o(pb_dir)
    );

    pfr_wake u_wake (
        .hclk(hclk),
        .hresetn(hresetn),
        .pins(pa_in),
        .wake_en(wake_en_q),
        .sleep_mode(sleep_mode),
        .wake_o(wake_w)
    );

    // Port B drive: general I/O unless a peripheral owns the pin
    logic [5:0] pb_out_d;
    logic [5:0] pb_oe_d;
    logic pin5_sdo;
    logic pin5_sck;
    assign pin5_sdo = (portb_pin5_select == PFR_PIN5_SDO); // RULE3
    assign pin5_sck = (portb_pin5_select == PFR_PIN5_SCK); // RULE3
    assign pb_out_d = {pin5_sdo ? serial_data_out_line : pin5_sck ? serial_clock_drive :
                       pb_data[5], pb_data[4:0]}; // RULE12
    assign pb_oe_d = {(pin5_sdo || pin5_sck) ? 1'b1 : !pb_dir[5],
                      (portb_pin4_select == PFR_PIN4_SDI) ? 1'b0 : !pb_dir[4], // RULE4
                      ~pb_dir[3:1],
                      analog_channel_0_en ? 1'b0 : !pb_dir[0]}; // RULE1

    // Registered pin drive
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pa_out_q <= PFR_PORT_RST;
            pa_oe_q <= PFR_SEL_RST;
            pb_out_q <= PFR_PORT_RST[5:0];
            pb_oe_q <= PFR_SEL_RST[5:0];
        end else begin
            pa_out_q <= pa_data; // RULE12
            pa_oe_q <= ~pa_dir;
            pb_out_q <= pb_out_d;
            pb_oe_q <= pb_oe_d;
        end
    end

    assign pa_out = pa_out_q;
    assign pa_oe = pa_oe_q;
    assign pb_out = pb_out_q;
    assign pb_oe = pb_oe_q;
    assign wake_req = wake_w;
    assign hrdata = hrdata_q;
    assign hreadyout = hreadyout_q;
    assign hresp = hresp_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    property p_pb0_analog;
        (portb_pin0_select == PFR_PIN0_ANALOG) |=> !pb_oe_q[0];
    endproperty
    a_pb0_analog: assert property (p_pb0_analog) else $error("pb0 driven in analog"); // RULE1

    property p_hi_zero;
        (ap_valid && !hwrite && (ap_addr == PFR_OFF_PB_HI_SEL || ap_addr == PFR_OFF_ROUTE1))
            |=> (hrdata_q[7:4] == 4'h0);
    endproperty
    a_hi_zero: assert property (p_hi_zero) else $error("upper nibble not zero"); // RULE2

    property p_pb5_sdo;
        pin5_sdo |=> (pb_oe_q[5] && pb_out_q[5] == $past(serial_data_out_line));
    endproperty
    a_pb5_sdo: assert property (p_pb5_sdo) else $error("pb5 not serial out"); // RULE3

    property p_pb4_sdi;
        (portb_pin4_select == PFR_PIN4_SDI) |=> !pb_oe_q[4];
    endproperty
    a_pb4_sdi: assert property (p_pb4_sdi) else $error("pb4 driven as input"); // RULE4

    property p_sck_route;
        (serial_clock_route == 2'b10) |-> (serial_clock_in == pb_in[5]);
    endproperty
    a_sck_route: assert property (p_sck_route) else $error("clock route wrong"); // RULE5

    property p_cap_route;
        (!capture_in_route[1]) |-> (timer_capture_input == pa_in[4]);
    endproperty
    a_cap_route: assert property (p_cap_route) else $error("capture route wrong"); // RULE7

    property p_cs_route;
        (chip_select_route == 2'b11) |-> (serial_chip_select == pa_in[0]);
    endproperty
    a_cs_route: assert property (p_cs_route) else $error("select route wrong"); // RULE10

    property p_pa_drive;
        1'b1 |=> (pa_out_q == $past(pa_data) && pa_oe_q == ~$past(pa_dir));
    endproperty
    a_pa_drive: assert property (p_pa_drive) else $error("pa drive mismatch"); // RULE12

    property p_bit_set;
        (bop_pa && bop_tgt == PFR_TGT_PA_DATA && bop_set)
            |=> (pa_data == ($past(pa_data) | (8'h01 << $past(bop_idx))));
    endproperty
    a_bit_set: assert property (p_bit_set) else $error("bit set lost other bits"); // RULE13

    c_read: cover property (ap_valid && !hwrite ##1 ap_valid && !hwrite);
    c_bitop: cover property (bop_pb);
    c_wake: cover property (sleep_mode ##1 wake_w);

endmodule : pfr_top

// ### design/pfr_pkg.sv
// Constants for the port pin-function and input-routing block
package pfr_pkg;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] PFR_OFF_PB_LO_SEL = 8'h00;
    localparam logic [7:0] PFR_OFF_PB_HI_SEL = 8'h04;
    localparam logic [7:0] PFR_OFF_ROUTE0 = 8'h08;
    localparam logic [7:0] PFR_OFF_ROUTE1 = 8'h0C;
    localparam logic [7:0] PFR_OFF_PA_DATA = 8'h10;
    localparam logic [7:0] PFR_OFF_PA_DIR = 8'h14;
    localparam logic [7:0] PFR_OFF_PB_DATA = 8'h18;
    localparam logic [7:0] PFR_OFF_PB_DIR = 8'h1C;
    localparam logic [7:0] PFR_OFF_WAKE_EN = 8'h20;
    localparam logic [7:0] PFR_OFF_BIT_OP = 8'h24;
    localparam logic [7:0] PFR_OFF_PIN_STAT = 8'h28;

    // ------------------------------------------------------------
    // Widths, reset values and masks
    // ------------------------------------------------------------
    localparam int unsigned PFR_PA_W = 8;
    localparam int unsigned PFR_PB_W = 6;
    localparam int unsigned PFR_DEC_W = 8;
    localparam logic [7:0] PFR_SEL_RST = 8'h00;
    localparam logic [7:0] PFR_PORT_RST = 8'hFF;
    localparam logic [7:0] PFR_LO_NIBBLE = 8'h0F;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int unsigned PFR_PIN0_SEL_LSB = 0;
    localparam int unsigned PFR_PIN4_SEL_LSB = 0;
    localparam int unsigned PFR_PIN5_SEL_LSB = 2;
    localparam int unsigned PFR_SCK_LSB = 6;
    localparam int unsigned PFR_SDI_LSB = 4;
    localparam int unsigned PFR_CAP_LSB = 2;
    localparam int unsigned PFR_TCK_LSB = 0;
    localparam int unsigned PFR_IRQ_LSB = 2;
    localparam int unsigned PFR_CS_LSB = 0;
    localparam int unsigned PFR_BOP_IDX_LSB = 0;
    localparam int unsigned PFR_BOP_TGT_LSB = 4;
    localparam int unsigned PFR_BOP_SET_BIT = 8;
    localparam int unsigned PFR_ST_PB_LSB = 8;
    localparam int unsigned PFR_ST_WAKE_BIT = 16;

    // ------------------------------------------------------------
    // Selection codes
    // ------------------------------------------------------------
    localparam logic [1:0] PFR_PIN0_ANALOG = 2'b01;
    localparam logic [1:0] PFR_PIN5_SDO = 2'b01;
    localparam logic [1:0] PFR_PIN5_SCK = 2'b10;
    localparam logic [1:0] PFR_PIN4_SDI = 2'b01;

    // Target of a single-bit set or clear
    typedef enum logic [1:0] {
        PFR_TGT_PA_DATA = 2'b00,
        PFR_TGT_PA_DIR = 2'b01,
        PFR_TGT_PB_DATA = 2'b10,
        PFR_TGT_PB_DIR = 2'b11
    } pfr_tgt_type;

endpackage : pfr_pkg

// ### design/pfr_port.sv
// Data and direction registers of one I/O port with bit set/clear
module pfr_port #(
    parameter int unsigned W = 8 // Pins on this port
) (
    input wire logic hclk, // System clock
    input wire logic hresetn, // Async reset, active low
    input wire logic data_wr, // Byte write to data register
    input wire logic dir_wr, // Byte write to direction register
    input wire logic [7:0] wr_byte, // Byte write value
    input wire logic bit_op, // Single-bit operation strobe
    input wire logic bit_on_dir, // Bit operation targets direction
    input wire logic bit_val, // New value of the addressed bit
    input wire logic [2:0] bit_idx, // Addressed bit
    output logic [W-1:0] data_o, // Data register
    output logic [W-1:0] dir_o // Direction register, 1 = input
);
    import pfr_pkg::*;

    logic [W-1:0] data_q;
    logic [W-1:0] data_d;
    logic [W-1:0] dir_q;
    logic [W-1:0] dir_d;
    logic [W-1:0] data_rmw;
    logic [W-1:0] dir_rmw;

    // ------------------------------------------------------------
    // Read whole byte, replace one bit, write back
    // ------------------------------------------------------------
    for (genvar i = 0; i < W; i++) begin : g_bit
        assign data_rmw[i] = (bit_idx == 3'(i)) ? bit_val : data_q[i]; // RULE13
        assign dir_rmw[i] = (bit_idx == 3'(i)) ? bit_val : dir_q[i]; // RULE13
    end

    // Next values
    assign data_d = data_wr ? wr_byte[W-1:0] : (bit_op && !bit_on_dir) ? data_rmw : data_q;
    assign dir_d = dir_wr ? wr_byte[W-1:0] : (bit_op && bit_on_dir) ? dir_rmw : dir_q;

    // Both registers come up all ones: every pin an input
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            data_q <= PFR_PORT_RST[W-1:0]; // RULE11
            dir_q <= PFR_PORT_RST[W-1:0]; // RULE11
        end else begin
            data_q <= data_d;
            dir_q <= dir_d;
        end
    end

    assign data_o = data_q;
    assign dir_o = dir_q;

endmodule : pfr_port

// ### design/pfr_wake.sv
// Port A falling-edge wake-up detector
module pfr_wake (
    input wire logic hclk, // System clock
    input wire logic hresetn, // Async reset, active low
    input wire logic [7:0] pins, // Port A pin levels
    input wire logic [7:0] wake_en, // Per-pin wake enable
    input wire logic sleep_mode, // Device in sleep or idle
    output logic wake_o // Wake request, held until sleep ends
);
    import pfr_pkg::*;

    logic [7:0] prev_q;
    logic wake_q;
    logic [7:0] fall;

    // Falling transition on an enabled pin
    assign fall = prev_q & ~pins & wake_en; // RULE14

    // Previous level and sticky wake while asleep
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prev_q <= PFR_PORT_RST;
            wake_q <= 1'b0;
        end else begin
            prev_q <= pins;
            wake_q <= sleep_mode && (wake_q || (|fall)); // RULE14
        end
    end

    assign wake_o = wake_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_wake_on_fall;
        @(posedge hclk) disable iff (!hresetn)
        (sleep_mode && (|($past(pins) & ~pins & wake_en))) |=> wake_q;
    endproperty
    a_wake_on_fall: assert property (p_wake_on_fall) else $error("no wake on fall"); // RULE14

    property p_no_wake_awake;
        @(posedge hclk) disable iff (!hresetn)
        !sleep_mode |=> !wake_q;
    endproperty
    a_no_wake_awake: assert property (p_no_wake_awake) else $error("wake while awake"); // RULE14

endmodule : pfr_wake

// ### sim/pfr_top_tb_top.sv
// Register-level testbench for the pin-function and routing block
module pfr_top_tb_top import pfr_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, sleep_mode, wake_req;
    logic serial_data_out_line, serial_clock_drive, serial_clock_in, serial_data_in_line;
    logic serial_chip_select, ext_irq_in, timer_capture_input, timer_external_clock_input;
    logic analog_channel_0_en;
    logic [31:0] haddr, hwdata, hrdata, d;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [7:0] pa_in, pa_out, pa_oe;
    logic [5:0] pb_in, pb_out, pb_oe;
    int fail_count = 0;
    int total_checks = 0;
    int sck_src[4] = '{2, 7, 13, 4};
    int sdi_src[4] = '{0, 1, 5, 12};
    int cap_src[4] = '{4, 4, 13, 13};
    int tck_src[4] = '{3, 3, 12, 12};
    int irq_src[4] = '{1, 1, 5, 7};
    int cs_src[4] = '{0, 3, 6, 0};
    logic [7:0] rst_ofs[9] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20};
    logic [7:0] rst_val[9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'h3F, 8'h3F, 8'h00};
    assign hready = hreadyout;
    pfr_top u_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
        .hreadyout, .hresp, .hrdata, .pa_in, .pa_out, .pa_oe, .pb_in, .pb_out, .pb_oe,
        .sleep_mode, .wake_req, .serial_data_out_line, .serial_clock_drive, .serial_clock_in,
        .serial_data_in_line, .serial_chip_select, .ext_irq_in, .timer_capture_input,
        .timer_external_clock_input, .analog_channel_0_en);
    // ------------------------------------------------------------
    // Bus tasks and checks
    // ------------------------------------------------------------
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'b10;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'b1);
        d = hrdata;
    endtask : xfer
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic settle();
        repeat (2) @(posedge hclk);
        @(negedge hclk);
    endtask : settle
    task automatic report_and_stop();
        if (fail_count == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : report_and_stop
    // Clock and watchdog
    initial begin
        hclk = 1'b0;
        forever #2.5 hclk = ~hclk;
    end
    initial begin
        #100us;
        fail_count++;
        report_and_stop();
    end
    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        {hresetn, hsel, hwrite, htrans, haddr, hwdata, sleep_mode} = '0;
        {serial_data_out_line, serial_clock_drive, pa_in, pb_in} = {2'b10, 14'h3FFF};
        hsize = 3'b010;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        for (int i = 0; i < 9; i++) begin
            xfer(rst_ofs[i], 1'b0, 32'h0);
            chk(d, {24'h0, rst_val[i]});
        end
        chk({pa_out, pa_oe}, 16'hFF00);
        chk({hresp, hreadyout}, 2'b01);
        xfer(PFR_OFF_PB_HI_SEL, 1'b1, 32'hFF);
        xfer(PFR_OFF_PB_HI_SEL, 1'b0, 32'h0);
        chk(d, 32'h0F);
        xfer(PFR_OFF_ROUTE1, 1'b1, 32'hFF);
        xfer(PFR_OFF_ROUTE1, 1'b0, 32'h0);
        chk(d, 32'h0F);
        xfer(8'h30, 1'b1, 32'h55);
        xfer(8'h30, 1'b0, 32'h0);
        chk(d, 32'h0);
        // Pin 5 driven by serial out then serial clock
        xfer(PFR_OFF_PB_HI_SEL, 1'b1, 32'h4);
        settle();
        chk({pb_oe[5], pb_out[5]}, 2'b11);
        xfer(PFR_OFF_PB_HI_SEL, 1'b1, 32'h8);
        settle();
        chk({pb_oe[5], pb_out[5]}, 2'b10);
        xfer(PFR_OFF_PB_DIR, 1'b1, 32'h0);
        xfer(PFR_OFF_PB_HI_SEL, 1'b1, 32'h1);
        settle();
        chk(pb_oe[5:4], 2'b10);
        xfer(PFR_OFF_PB_HI_SEL, 1'b1, 32'h0);
        settle();
        chk(pb_oe[5:4], 2'b11);
        chk(pb_out[4:0], 5'h1F);
        for (int c = 0; c < 4; c++) begin
            xfer(PFR_OFF_PB_LO_SEL, 1'b1, 32'(c));
            settle();
            chk({analog_channel_0_en, pb_oe[0]}, {c == 1, c != 1});
        end
        // Every routing code against every source pin
        for (int c = 0; c < 4; c++) begin
            xfer(PFR_OFF_ROUTE0, 1'b1, 32'(c * 8'h55));
            xfer(PFR_OFF_ROUTE1, 1'b1, 32'(c * 8'h05));
            for (int p = 0; p < 14; p++) begin
                @(posedge hclk);
                {pb_in, pa_in} <= 14'(1 << p);
                settle();
                chk({serial_clock_in, serial_data_in_line, timer_capture_input,
                    timer_external_clock_input, ext_irq_in, serial_chip_select},
                    {sck_src[c] == p, sdi_src[c] == p, cap_src[c] == p, tck_src[c] == p,
                    irq_src[c] == p, cs_src[c] == p});
            end
        end
        // Outputs drive high until data is written
        xfer(PFR_OFF_PA_DIR, 1'b1, 32'h0);
        settle();
        chk({pa_out, pa_oe}, 16'hFFFF);
        xfer(PFR_OFF_PA_DATA, 1'b1, 32'h5A);
        settle();
        chk(pa_out, 8'h5A);
        xfer(PFR_OFF_BIT_OP, 1'b1, 32'h001);
        xfer(PFR_OFF_BIT_OP, 1'b1, 32'h117);
        xfer(PFR_OFF_PA_DATA, 1'b0, 32'h0);
        chk(d, 32'h58);
        xfer(PFR_OFF_PA_DIR, 1'b0, 32'h0);
        chk(d, 32'h80);
        xfer(PFR_OFF_BIT_OP, 1'b0, 32'h0);
        chk(d, 32'h0);
        xfer(PFR_OFF_BIT_OP, 1'b1, 32'h023);
        xfer(PFR_OFF_BIT_OP, 1'b1, 32'h134);
        xfer(PFR_OFF_PB_DATA, 1'b0, 32'h0);
        chk(d, 32'h37);
        xfer(PFR_OFF_PB_DIR, 1'b0, 32'h0);
        chk(d, 32'h10);
        // Wake on enabled falling edge only
        xfer(PFR_OFF_WAKE_EN, 1'b1, 32'h04);
        @(posedge hclk);
        {pb_in, pa_in} <= 14'h3FFF;
        sleep_mode <= 1'b1;
        @(posedge hclk);
        pa_in <= 8'hF7;
        settle();
        chk(wake_req, 1'b0);
        @(posedge hclk);
        pa_in <= 8'hFB;
        settle();
        chk(wake_req, 1'b1);
        xfer(PFR_OFF_PIN_STAT, 1'b0, 32'h0);
        chk(d, 32'h13FFB);
        sleep_mode <= 1'b0;
        settle();
        chk(wake_req, 1'b0);
        report_and_stop();
    end
endmodule : pfr_top_tb_top
